// file: fopr_pkg.sv
// package for the flash option and protection register block
package fopr_pkg;

  // ------------------------------------------------------------
  // register offsets on the plain register port
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_OPTIONS = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h1;
  localparam logic [3:0] OFS_PROTECT = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;

  // ------------------------------------------------------------
  // field positions, masks and reset values
  // ------------------------------------------------------------
  localparam int OPT_KEY_USE_BIT = 7;
  localparam int OPT_NORED_BIT = 6;
  localparam logic [7:0] OPT_USED_MASK = 8'hc3;
  localparam logic [1:0] SEC_UNSECURE = 2'h2;
  localparam int CFG_KEY_ACCESS_BIT = 5;
  localparam logic [7:0] CFG_RW_MASK = 8'he0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int PROT_OPEN_BIT = 7;
  localparam int PROT_DIS_BIT = 6;
  localparam int PROT_SIZE_LSB = 3;
  localparam logic [7:0] PROT_USED_MASK = 8'hf8;
  localparam int STAT_VIOL_BIT = 5;

  // ------------------------------------------------------------
  // protection sizes and address windows
  // ------------------------------------------------------------
  localparam logic [2:0] SIZE_ALL = 3'h7;
  localparam logic [2:0] SIZE_32K_UP = 3'h5;
  localparam logic [2:0] SIZE_60K_ONLY = 3'h6;
  localparam int SIZE_BASE_SHIFT = 9;
  localparam logic [15:0] PROT_START_ALL = 16'h182c;
  localparam logic [15:0] BLOCK_BASE_SIZE = 16'h0200;
  localparam logic [15:0] KEY_LO_ADDR = 16'hffb0;
  localparam logic [3:0] KEY_BYTES = 4'h8;
  localparam logic [15:0] VEC_LO = 16'hffc0;
  localparam logic [15:0] VEC_HI = 16'hfffd;
  localparam logic [15:0] RESET_VEC = 16'hfffe;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;           // write strobe
    logic rd;           // read strobe
    logic from_debug;   // access issued by background debug
    logic [3:0] addr;   // register offset
    logic [7:0] wdata;  // write data
  } fopr_bus_s;

  typedef struct packed {
    logic wr;           // flash array write
    logic rd;           // flash array read
    logic from_debug;   // access issued by background debug
    logic [15:0] addr;  // flash address
    logic [7:0] wdata;  // write data
  } fopr_flash_s;

  typedef struct packed {
    logic valid;        // command being registered
    logic mass;         // mass erase, whole array
    logic [15:0] addr;  // target address
  } fopr_cmd_s;

endpackage

// file: fopr_regs.sv
// flash option, configuration and protection registers
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps

// Behaviour
// - reset copies nonvolatile options byte into options
// - options bits 5:2 read zero, writes ignored
// - key enable zero blocks backdoor unlock
// - key bytes only from firmware, not debug
// - matching eight ascending key bytes unsecures device
// - options bit 6 disables vector redirection
// - only security code 10 means unsecured
// - secure blocks memory access from debug source
// - key match or blank check forces code 10
// - configuration bits 7:5 rw, 4:0 zero
// - key access clear: writes start commands
// - key access set: capture key, reads invalid
// - reset loads protection; bits 2:0 zero
// - protection writable only from debug, upper five
// - open bit zero blocks all program/erase
// - bit 6 one protects no block
// - size code selects top block; 111 all
// - refuse program/erase inside protected block
// - redirect below block; not closed/disabled/111
// - reset vector never redirected
// - codes 101/110 only on larger variants
// - clearing key access triggers key comparison
// - protected command ignored, violation flag set
module fopr_regs #(
  parameter int FLASH_KB = 60  // flash size variant in kilobytes
) (
  input wire logic ref_clk,                   // bus clock
  input wire logic rst_n,                     // sync reset, active low
  input wire fopr_pkg::fopr_bus_s bus,        // register port request
  output logic [7:0] rdata,                   // read data, next cycle
  input wire logic [7:0] nv_options_byte,     // options byte in flash
  input wire logic [7:0] nv_protection_byte,  // protection byte in flash
  input wire logic [63:0] backdoor_key_bytes, // key, byte 0 in [7:0]
  input wire fopr_pkg::fopr_flash_s fl,       // flash array access
  output logic cmd_first_step,                // write starts a command
  output logic read_invalid,                  // flash reads invalid
  output logic access_denied,                 // access blocked, secure
  output logic secure,                        // device secured
  input wire fopr_pkg::fopr_cmd_s cmd,        // registered command
  output logic cmd_go,                        // command allowed
  input wire logic blank_ok,                  // blank check all erased
  input wire logic [15:0] vec_in,             // vector fetch address
  output logic [15:0] vec_addr                // fetch address, next cycle
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] opt_reg;
  logic [7:0] cfg_reg;
  logic [7:0] prot_reg;
  logic viol_reg;
  logic [7:0] key_reg [8];
  logic [3:0] key_cnt_reg;
  logic key_bad_reg;
  logic [7:0] rdata_reg;
  logic [15:0] vec_reg;

  logic key_access;
  logic cfg_wr;
  logic key_access_fall;
  logic key_wr;
  logic key_eq;
  logic unlock;
  logic [2:0] size_code;
  logic prot_active;
  logic [15:0] prot_start;
  logic [15:0] prot_size;
  logic in_block;
  logic viol;
  logic code_ok;
  logic redir_on;

  // ------------------------------------------------------------
  // decodes
  // ------------------------------------------------------------
  assign key_access = cfg_reg[fopr_pkg::CFG_KEY_ACCESS_BIT];
  assign cfg_wr = bus.wr && bus.addr == fopr_pkg::OFS_CONFIG;
  // comparison fires when key access goes from one to zero
  assign key_access_fall = cfg_wr && key_access &&
                           !bus.wdata[fopr_pkg::CFG_KEY_ACCESS_BIT];
  assign key_wr = fl.wr && key_access &&
                  fl.addr[15:3] == fopr_pkg::KEY_LO_ADDR[15:3];

  // byte i of the key sits at the i-th key address
  always_comb begin
    key_eq = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (key_reg[i] != backdoor_key_bytes[8*i +: 8]) begin
        key_eq = 1'b0;
      end
    end
  end

  // full, ordered, matching key with key use enabled
  assign unlock = key_access_fall &&
                  opt_reg[fopr_pkg::OPT_KEY_USE_BIT] &&
                  key_cnt_reg == fopr_pkg::KEY_BYTES &&
                  !key_bad_reg && key_eq;

  // only code 10 unsecures
  assign secure = opt_reg[1:0] != fopr_pkg::SEC_UNSECURE;
  // debug source kept off memory while secure
  assign access_denied = secure && fl.from_debug && (fl.wr || fl.rd);

  // flash writes with key access clear launch commands
  assign cmd_first_step = fl.wr && !key_access;
  assign read_invalid = key_access;

  // ------------------------------------------------------------
  // options register
  // ------------------------------------------------------------
  // loaded during reset, bus writes have no path in
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      opt_reg <= nv_options_byte & fopr_pkg::OPT_USED_MASK;
    end else if (unlock || blank_ok) begin
      opt_reg[1:0] <= fopr_pkg::SEC_UNSECURE;
    end
  end

  // ------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_reg <= fopr_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_reg <= bus.wdata & fopr_pkg::CFG_RW_MASK;
    end
  end

  // ------------------------------------------------------------
  // comparison key capture
  // ------------------------------------------------------------
  // bytes must arrive in ascending order from firmware only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      key_cnt_reg <= 4'h0;
      key_bad_reg <= 1'b0;
    end else if (cfg_wr) begin
      key_cnt_reg <= 4'h0;
      key_bad_reg <= 1'b0;
    end else if (key_wr && !fl.from_debug) begin
      if (key_cnt_reg < fopr_pkg::KEY_BYTES &&
          fl.addr[2:0] == key_cnt_reg[2:0]) begin
        key_cnt_reg <= key_cnt_reg + 4'h1;
      end else begin
        key_bad_reg <= 1'b1;
      end
    end
  end

  // key byte storage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        key_reg[i] <= 8'h00;
      end
    end else if (key_wr && !fl.from_debug) begin
      key_reg[fl.addr[2:0]] <= fl.wdata;
    end
  end

  // ------------------------------------------------------------
  // protection register
  // ------------------------------------------------------------
  // user writes dropped, debug writes reach bits 7:3
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prot_reg <= nv_protection_byte & fopr_pkg::PROT_USED_MASK;
    end else if (bus.wr && bus.addr == fopr_pkg::OFS_PROTECT &&
                 bus.from_debug) begin
      prot_reg <= bus.wdata & fopr_pkg::PROT_USED_MASK;
    end
  end

  // ------------------------------------------------------------
  // protected block and command check
  // ------------------------------------------------------------
  assign size_code = prot_reg[fopr_pkg::PROT_SIZE_LSB +: 3];
  assign prot_active = !prot_reg[fopr_pkg::PROT_DIS_BIT];
  assign prot_size = fopr_pkg::BLOCK_BASE_SIZE << size_code;
  // top block doubles per code; top code covers almost all
  assign prot_start = (size_code == fopr_pkg::SIZE_ALL) ?
                      fopr_pkg::PROT_START_ALL :
                      16'h0000 - prot_size;
  assign in_block = prot_active && cmd.addr >= prot_start;
  // closed array or hit inside the block refuses the command
  assign viol = !prot_reg[fopr_pkg::PROT_OPEN_BIT] ||
                (cmd.mass ? prot_active : in_block);
  assign cmd_go = cmd.valid && !viol;

  // violation flag, set wins over a write-one clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      viol_reg <= 1'b0;
    end else if (cmd.valid && viol) begin
      viol_reg <= 1'b1;
    end else if (bus.wr && bus.addr == fopr_pkg::OFS_STATUS &&
                 bus.wdata[fopr_pkg::STAT_VIOL_BIT]) begin
      viol_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // vector redirection
  // ------------------------------------------------------------
  // larger size codes exist only on the larger variants
  assign code_ok = size_code != fopr_pkg::SIZE_ALL &&
                   (size_code != fopr_pkg::SIZE_32K_UP ||
                    FLASH_KB >= 32) &&
                   (size_code != fopr_pkg::SIZE_60K_ONLY ||
                    FLASH_KB >= 60);
  assign redir_on = prot_reg[fopr_pkg::PROT_OPEN_BIT] && prot_active &&
                    !opt_reg[fopr_pkg::OPT_NORED_BIT] && code_ok;

  // vectors move down by one block size, reset vector stays
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vec_reg <= 16'h0000;
    end else if (redir_on && vec_in >= fopr_pkg::VEC_LO &&
                 vec_in <= fopr_pkg::VEC_HI) begin
      vec_reg <= vec_in - prot_size;
    end else begin
      vec_reg <= vec_in;
    end
  end
  assign vec_addr = vec_reg;

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  // data valid in the cycle after the strobe, unmapped read zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        fopr_pkg::OFS_OPTIONS: rdata_reg <= opt_reg;
        fopr_pkg::OFS_CONFIG: rdata_reg <= cfg_reg;
        fopr_pkg::OFS_PROTECT: rdata_reg <= prot_reg;
        fopr_pkg::OFS_STATUS: rdata_reg <= {2'h0, viol_reg, 5'h00};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata = rdata_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_opt_write_ign: assert property (
    bus.wr && bus.addr == fopr_pkg::OFS_OPTIONS && !unlock && !blank_ok
    |=> $stable(opt_reg))
    else $error("options register changed by a bus write");

  a_opt_res_zero: assert property (opt_reg[5:2] == 4'h0)
    else $error("options reserved bits not zero");

  a_key_use_off: assert property (
    key_access_fall && !opt_reg[fopr_pkg::OPT_KEY_USE_BIT] && !blank_ok
    |=> $stable(opt_reg[1:0]))
    else $error("unlock with key use disabled");

  a_debug_key_ign: assert property (
    key_wr && fl.from_debug && !cfg_wr |=> $stable(key_cnt_reg))
    else $error("debug write captured as key byte");

  a_key_unlock: assert property (
    unlock |=> !secure ##1 !secure)
    else $error("matching key did not unsecure");

  a_nored_stop: assert property (
    opt_reg[fopr_pkg::OPT_NORED_BIT] && vec_in >= fopr_pkg::VEC_LO
    |=> vec_addr == $past(vec_in))
    else $error("vector redirected while disabled");

  a_debug_denied: assert property (
    opt_reg[1:0] == 2'h0 && fl.from_debug && fl.rd |-> access_denied)
    else $error("debug read allowed while secure");

  a_blank_unsec: assert property (blank_ok |=> !secure)
    else $error("blank check did not unsecure");

  a_cfg_low_zero: assert property (cfg_reg[4:0] == 5'h00)
    else $error("configuration low bits not zero");

  a_cmd_step: assert property (
    fl.wr && !fl.from_debug && key_access && !cfg_wr &&
    fl.addr == fopr_pkg::KEY_LO_ADDR
    |-> !cmd_first_step ##1 key_reg[0] == $past(fl.wdata))
    else $error("key window write not captured");

  a_prot_user_ign: assert property (
    bus.wr && bus.addr == fopr_pkg::OFS_PROTECT && !bus.from_debug
    |=> $stable(prot_reg))
    else $error("user write reached protection register");

  a_prot_low_zero: assert property (prot_reg[2:0] == 3'h0)
    else $error("protection low bits not zero");

  a_closed_refuse: assert property (
    cmd.valid && !prot_reg[fopr_pkg::PROT_OPEN_BIT]
    |-> !cmd_go ##1 viol_reg)
    else $error("command passed with flash closed");

  a_block_refuse: assert property (
    cmd.valid && !cmd.mass && !prot_reg[fopr_pkg::PROT_DIS_BIT] &&
    size_code == 3'h0 && cmd.addr >= 16'hfe00 |-> !cmd_go)
    else $error("command passed inside protected block");

  a_redir_low: assert property (
    redir_on && size_code == 3'h0 && vec_in == 16'hffc0
    |=> vec_addr == 16'hfdc0)
    else $error("vector not moved below block");

  a_reset_vec: assert property (
    vec_in == fopr_pkg::RESET_VEC |=> vec_addr == fopr_pkg::RESET_VEC)
    else $error("reset vector redirected");

  a_variant_gate: assert property (
    size_code == fopr_pkg::SIZE_60K_ONLY && FLASH_KB < 60 |-> !redir_on)
    else $error("redirection on missing variant code");

  a_reset_reload: assert property (
    $rose(rst_n) |-> !key_access &&
    opt_reg == ($past(nv_options_byte) & fopr_pkg::OPT_USED_MASK) &&
    prot_reg == ($past(nv_protection_byte) & fopr_pkg::PROT_USED_MASK))
    else $error("reset did not reload state");

  c_key_unlock: cover property (unlock ##1 !secure);
  c_blank_unlock: cover property (secure && blank_ok);
  c_violation: cover property (cmd.valid && viol ##1 viol_reg);
  c_redirect: cover property (redir_on && vec_in == fopr_pkg::VEC_LO);

endmodule

// file: fopr_tb.sv
// self-checking testbench for the flash option and protection registers
`timescale 1ns/1ps

module testbench;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  fopr_pkg::fopr_bus_s bus = '0;
  fopr_pkg::fopr_flash_s fl = '0;
  fopr_pkg::fopr_cmd_s cmd = '0;
  logic [7:0] rdata;
  logic [7:0] nv_opt = 8'h80;
  logic [7:0] nv_prot = 8'h87;
  logic [63:0] key = '0;
  logic blank_ok = 1'h0;
  logic [15:0] vec_in = '0;
  logic [15:0] vec_addr;
  logic cmd_first_step, read_invalid, access_denied, secure, cmd_go;
  logic [7:0] rd_q[$];
  logic rd_pend = 1'h0;
  logic [15:0] st;
  logic [15:0] va;
  int fails = 0;
  int n_tests = 0;

  // ------------------------------------------------------------
  // clock, design, comparisons
  // ------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  fopr_regs #(.FLASH_KB(60)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .nv_options_byte(nv_opt), .nv_protection_byte(nv_prot),
    .backdoor_key_bytes(key), .fl(fl), .cmd_first_step(cmd_first_step),
    .read_invalid(read_invalid), .access_denied(access_denied),
    .secure(secure), .cmd(cmd), .cmd_go(cmd_go), .blank_ok(blank_ok),
    .vec_in(vec_in), .vec_addr(vec_addr));

  task automatic cmp_addr(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_addr({15'h0, got}, {15'h0, exp});
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_addr({8'h0, got}, {8'h0, exp});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // read data watcher, one cycle after each read strobe
  always @(negedge ref_clk) begin
    if (rd_pend) begin
      if (rd_q.size() == 0) begin
        fails++;
        $display("ERROR t=%0t got %h exp none", $time, rdata);
      end else begin
        cmp_byte(rdata, rd_q.pop_front());
      end
    end
    rd_pend = bus.rd;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    $display("ERROR t=%0t got %h exp %h", $time, 1'h0, 1'h1);
    wrap_up();
  end

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d,
                        input logic dbg);
    @(posedge ref_clk);
    bus <= '{wr: 1'h1, rd: 1'h0, from_debug: dbg, addr: a, wdata: d};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus <= '{wr: 1'h0, rd: 1'h1, from_debug: 1'h0, addr: a, wdata: 8'h0};
    rd_q.push_back(exp);
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task automatic cmd_chk(input logic [15:0] a, input logic m,
                         input logic go);
    @(posedge ref_clk);
    cmd <= '{valid: 1'h1, mass: m, addr: a};
    @(negedge ref_clk);
    cmp_bit(cmd_go, go);
    @(posedge ref_clk);
    cmd <= '0;
  endtask

  task automatic vec_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    vec_in <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_addr(vec_addr, exp);
  endtask

  task automatic flash_op(input logic w, input logic dbg,
                          input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    fl <= '{wr: w, rd: ~w, from_debug: dbg, addr: a, wdata: d};
  endtask

  // key access on, eight ascending key bytes, key access off
  task automatic key_entry(input logic [63:0] k, input logic dbg);
    reg_wr(fopr_pkg::OFS_CONFIG, 8'h20, 1'h0);
    for (int i = 0; i < 8; i++) begin
      flash_op(1'h1, dbg, 16'hffb0 + 16'(i), k[8*i +: 8]);
    end
    @(posedge ref_clk);
    fl <= '0;
    reg_wr(fopr_pkg::OFS_CONFIG, 8'h00, 1'h0);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
    @(posedge ref_clk);
    rst_n <= 1'h0;
    nv_opt <= o;
    nv_prot <= p;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(negedge ref_clk);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(48039));
    key = {$urandom(), $urandom()};
    do_reset(8'h80, 8'h87);
    cmp_bit(secure, 1'h1);
    reg_rd(fopr_pkg::OFS_OPTIONS, 8'h80);
    reg_wr(fopr_pkg::OFS_OPTIONS, 8'hff, 1'h0);
    reg_wr(fopr_pkg::OFS_OPTIONS, 8'h3c, 1'h1);
    reg_rd(fopr_pkg::OFS_OPTIONS, 8'h80);
    reg_rd(fopr_pkg::OFS_PROTECT, 8'h80);
    reg_wr(fopr_pkg::OFS_PROTECT, 8'h40, 1'h0);
    reg_rd(fopr_pkg::OFS_PROTECT, 8'h80);
    reg_wr(fopr_pkg::OFS_CONFIG, 8'hff, 1'h0);
    reg_rd(fopr_pkg::OFS_CONFIG, 8'he0);
    cmp_bit(read_invalid, 1'h1);
    reg_wr(fopr_pkg::OFS_CONFIG, 8'h00, 1'h0);
    reg_rd(4'h9, 8'h00);
    // flash port flags while secured
    flash_op(1'h1, 1'h0, 16'hffb3, 8'h5a);
    @(negedge ref_clk);
    cmp_bit(cmd_first_step, 1'h1);
    flash_op(1'h0, 1'h1, 16'h2000, 8'h00);
    @(negedge ref_clk);
    cmp_bit(access_denied, 1'h1);
    @(posedge ref_clk);
    fl <= '0;
    // every size code: boundary, inside, vector placement
    for (int c = 0; c < 8; c++) begin
      st = (c == 7) ? 16'h182c : 16'h0000 - (16'h0200 << c);
      reg_wr(fopr_pkg::OFS_PROTECT, {2'h2, c[2:0], 3'h7}, 1'h1);
      reg_rd(fopr_pkg::OFS_PROTECT, {2'h2, c[2:0], 3'h0});
      cmd_chk(st, 1'h0, 1'h0);
      cmd_chk(st - 16'h1, 1'h0, 1'h1);
      cmd_chk(st + 16'($urandom_range(0, 16'hffff - st)), 1'h0, 1'h0);
      va = 16'hffc0 + 16'($urandom_range(0, 61));
      vec_chk(va, (c == 7) ? va : va - (16'h0200 << c));
    end
    reg_rd(fopr_pkg::OFS_STATUS, 8'h20);
    reg_wr(fopr_pkg::OFS_STATUS, 8'h20, 1'h0);
    reg_rd(fopr_pkg::OFS_STATUS, 8'h00);
    reg_wr(fopr_pkg::OFS_PROTECT, 8'h80, 1'h1);
    vec_chk(16'hfffe, 16'hfffe);
    vec_chk(16'hffc0, 16'hfdc0);
    cmd_chk(16'h1000, 1'h1, 1'h0);
    reg_wr(fopr_pkg::OFS_PROTECT, 8'h00, 1'h1);
    cmd_chk(16'h1000, 1'h0, 1'h0);
    vec_chk(16'hffc4, 16'hffc4);
    reg_wr(fopr_pkg::OFS_PROTECT, 8'hc0, 1'h1);
    cmd_chk(16'hfff0, 1'h0, 1'h1);
    // backdoor key: wrong byte, debug source, then correct
    key_entry(key ^ 64'h0000_0000_0000_0100, 1'h0);
    cmp_bit(secure, 1'h1);
    key_entry(key, 1'h1);
    cmp_bit(secure, 1'h1);
    key_entry(key, 1'h0);
    cmp_bit(secure, 1'h0);
    reg_rd(fopr_pkg::OFS_OPTIONS, 8'h82);
    // second reset: key disabled, redirection disabled
    reg_wr(fopr_pkg::OFS_CONFIG, 8'he0, 1'h0);
    do_reset(8'h41, 8'h80);
    cmp_bit(secure, 1'h1);
    cmp_bit(read_invalid, 1'h0);
    reg_rd(fopr_pkg::OFS_CONFIG, 8'h00);
    reg_rd(fopr_pkg::OFS_PROTECT, 8'h80);
    key_entry(key, 1'h0);
    cmp_bit(secure, 1'h1);
    vec_chk(16'hffc0, 16'hffc0);
    @(posedge ref_clk);
    blank_ok <= 1'h1;
    @(posedge ref_clk);
    blank_ok <= 1'h0;
    @(negedge ref_clk);
    cmp_bit(secure, 1'h0);
    reg_rd(fopr_pkg::OFS_OPTIONS, 8'h42);
    repeat (3) @(posedge ref_clk);
    wrap_up();
  end
endmodule
